/* rtl/st_regs_pkg.sv */
package st_regs_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int CNT_W = 5;
  localparam int FRAME_W = 5;

  localparam logic [ADDR_W-1:0] ADDR_RX_STATUS = 4'h5;
  localparam logic [ADDR_W-1:0] ADDR_TRIG = 4'h6;
  localparam logic [ADDR_W-1:0] ADDR_MF_STATUS = 4'h7;
  localparam logic [ADDR_W-1:0] ADDR_LINE_CTRL = 4'h8;
  localparam logic [ADDR_W-1:0] ADDR_ECHO_STATUS = 4'hA;

  localparam logic [DATA_W-1:0] TRIG_RST = 8'h00;
  localparam logic [DATA_W-1:0] LINE_RST = 8'h00;
  localparam logic [DATA_W-1:0] LINE_MASK = 8'h23;

  localparam int LC_CLRMM_BIT = 0;
  localparam int LC_SWAP_BIT = 1;
  localparam int LC_SSM_BIT = 5;

  localparam logic [3:0] IDLE_RUN = 4'hF;
  localparam logic [CNT_W-1:0] QUEUE_FULL = 5'h10;
  localparam logic [FRAME_W-1:0] FRAME_FIRST = 5'h01;
  localparam logic [FRAME_W-1:0] MF_FRAMES = 5'h14;
  localparam logic [2:0] MSE_DELAY = 3'h7;
  localparam logic [FRAME_W-1:0] SG_END0 = 5'h05;
  localparam logic [FRAME_W-1:0] SG_END1 = 5'h0A;
  localparam logic [FRAME_W-1:0] SG_END2 = 5'h0F;
  localparam logic [FRAME_W-1:0] QF_B = 5'h06;
  localparam logic [FRAME_W-1:0] QF_C = 5'h0B;
  localparam logic [FRAME_W-1:0] QF_D = 5'h10;

  // Code 0 stands for a full sixteen-byte queue
  function automatic logic thr_reached(input logic [CNT_W-1:0] cnt, input logic [3:0] thr);
    thr_reached = (thr == 4'h0) ? (cnt >= QUEUE_FULL) : (cnt >= {1'b0, thr});
  endfunction

  function automatic logic majority5(input logic [4:0] v);
    logic [2:0] ones;
    ones = 3'h0;
    for (int i = 0; i < 5; i++) begin
      ones = ones + {2'h0, v[i]};
    end
    majority5 = (ones >= 3'h3);
  endfunction

  // {valid, slot}: frame that closes a group of five S bits
  function automatic logic [2:0] vote_slot(input logic [FRAME_W-1:0] frame);
    case (frame)
      SG_END0: vote_slot = 3'h4;
      SG_END1: vote_slot = 3'h5;
      SG_END2: vote_slot = 3'h6;
      MF_FRAMES: vote_slot = 3'h7;
      default: vote_slot = 3'h0;
    endcase
  endfunction

  // {valid, state}: multiframe state taken on in a Q-bit frame
  function automatic logic [2:0] q_state(input logic [FRAME_W-1:0] frame);
    case (frame)
      FRAME_FIRST: q_state = 3'h5;
      QF_B: q_state = 3'h6;
      QF_C: q_state = 3'h7;
      QF_D: q_state = 3'h4;
      default: q_state = 3'h0;
    endcase
  endfunction
endpackage

/* rtl/mf_link_if.sv */
`timescale 1ns/1ns
interface mf_link_if;
  logic frame_stb;
  logic m_bit;
  logic frame_sync;
  logic mse;
  logic [4:0] frame_no;
  modport tracker (input frame_stb, input m_bit, input frame_sync, output mse, output frame_no);
  modport user (output frame_stb, output m_bit, output frame_sync, input mse, input frame_no);
endinterface

/* rtl/mf_sync_tracker.sv */
`timescale 1ns/1ns
module mf_sync_tracker (
  input wire logic clk_i,
  input wire logic rst_i,
  mf_link_if.tracker mf
);
  import st_regs_pkg::*;

  logic [FRAME_W-1:0] gap_q, gap_d, frame_q, frame_d, gap_inc;
  logic seen_q, seen_d, mse_q, mse_d, tgt_q, tgt_d, good, bad;
  logic [2:0] pend_q, pend_d;

  always_comb begin
    gap_d = gap_q;
    frame_d = frame_q;
    seen_d = seen_q;
    mse_d = mse_q;
    tgt_d = tgt_q;
    pend_d = pend_q;
    gap_inc = (gap_q > MF_FRAMES) ? gap_q : gap_q + 5'h01;
    good = mf.m_bit && seen_q && (gap_inc == MF_FRAMES);
    // Wrong M spacing, or the expected M never came
    bad = mf.m_bit ? !good : (seen_q && gap_inc == MF_FRAMES);
    if (!mf.frame_sync) begin
      mse_d = 1'b0;
      seen_d = 1'b0;
      pend_d = 3'h0;
      gap_d = 5'h00;
      frame_d = FRAME_FIRST;
    end else if (mf.frame_stb) begin
      gap_d = gap_inc;
      frame_d = (frame_q == MF_FRAMES) ? FRAME_FIRST : frame_q + 5'h01;
      if (pend_q != 3'h0) begin
        pend_d = pend_q - 3'h1;
        if (pend_q == 3'h1) begin
          mse_d = tgt_q;
        end
      end
      if (mf.m_bit) begin
        gap_d = 5'h00;
        frame_d = FRAME_FIRST;
        seen_d = 1'b1;
      end
      if (good && !mse_q && pend_q == 3'h0) begin
        pend_d = MSE_DELAY;
        tgt_d = 1'b1;
      end else if (bad && mse_q && (pend_q == 3'h0 || tgt_q)) begin
        pend_d = MSE_DELAY;
        tgt_d = 1'b0;
      end else if (bad && !mse_q) begin
        pend_d = 3'h0;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      gap_q <= 5'h00;
      frame_q <= FRAME_FIRST;
      seen_q <= 1'b0;
      mse_q <= 1'b0;
      tgt_q <= 1'b0;
      pend_q <= 3'h0;
    end else begin
      gap_q <= gap_d;
      frame_q <= frame_d;
      seen_q <= seen_d;
      mse_q <= mse_d;
      tgt_q <= tgt_d;
      pend_q <= pend_d;
    end
  end

  assign mf.mse = mse_q;
  assign mf.frame_no = frame_q;

  a_mse_loss_drop: assert property (@(posedge clk_i) disable iff (rst_i)
    !mf.frame_sync |=> !mse_q) else $error("mse kept after frame sync loss");
  a_mse_rise_timed: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(mse_q) |-> $past(mf.frame_stb) && $past(pend_q) == 3'h1 && $past(tgt_q))
    else $error("mse rose outside its frame");
  a_good_m_arms: assert property (@(posedge clk_i) disable iff (rst_i)
    mf.frame_sync && mf.frame_stb && mf.m_bit && seen_q && gap_q + 5'h01 == MF_FRAMES
    && !mse_q && pend_q == 3'h0 |=> pend_q == MSE_DELAY && tgt_q)
    else $error("good M spacing did not arm sync");
endmodule

/* rtl/isdn_st_status_control_regs.sv */
// Contract
// - Fifteen ones on received D sets idle
// - EOF flag while marker queued; count to it
// - Transmit-empty interrupt at empty-byte threshold
// - Receive-fill interrupt at fill threshold
// - Unvoted: last five S bits, oldest low
// - Voted: four group results, bit four zero
// - Multiframe state code per Q frame
// - State updates at marker in frames 1,6,11,16
// - Sync needs M bits exactly twenty apart
// - Sync changes mid frame eight
// - Frame sync loss drops sync at once
// - Mismatch sets flag, forces D all ones
// - Reading mismatch register clears flag
// - Channel exchange swaps B1 and B2 both ways
// - Low five status bits give byte count
`timescale 1ns/1ns
module isdn_st_status_control_regs (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [st_regs_pkg::ADDR_W-1:0] addr_i,
  input wire logic [st_regs_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [st_regs_pkg::DATA_W-1:0] rdata_o,
  input wire logic d_rx_bit_i,
  input wire logic d_rx_bit_stb_i,
  input wire logic [st_regs_pkg::CNT_W-1:0] rxq_count_i,
  input wire logic [st_regs_pkg::CNT_W-1:0] rxq_eof_count_i,
  input wire logic rxq_eof_i,
  input wire logic [st_regs_pkg::CNT_W-1:0] txq_empty_i,
  output logic tx_empty_irq_o,
  output logic rx_fill_irq_o,
  input wire logic frame_stb_i,
  input wire logic frame_sync_i,
  input wire logic m_bit_i,
  input wire logic s_bit_i,
  input wire logic qbm_i,
  input wire logic echo_mismatch_i,
  output logic d_tx_force_ones_o,
  output logic d_contention_off_o,
  input wire logic b_byte_stb_i,
  input wire logic [7:0] nt_rx_b1_i,
  input wire logic [7:0] nt_rx_b2_i,
  input wire logic [7:0] tx_first_bchan_in_i,
  input wire logic [7:0] tx_second_bchan_in_i,
  output logic [7:0] rx_serial_out_b1_o,
  output logic [7:0] rx_serial_out_b2_o,
  output logic [7:0] nt_tx_b1_o,
  output logic [7:0] nt_tx_b2_o
);
  import st_regs_pkg::*;

  mf_link_if mfl ();

  assign mfl.frame_stb = frame_stb_i;
  assign mfl.m_bit = m_bit_i;
  assign mfl.frame_sync = frame_sync_i;

  mf_sync_tracker u_tracker (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .mf(mfl.tracker)
  );

  // Register file and read port

  logic [DATA_W-1:0] trig_q, trig_d, line_q, line_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic [3:0] idle_cnt_q;
  logic [4:0] s_raw_q;
  logic [3:0] s_vote_q;
  logic [1:0] mf_st_q;
  logic mf_valid_q, mismatch_q;
  logic [CNT_W-1:0] rx_status_cnt;
  logic [4:0] s_chan_bits;
  logic ssm, clrmm, b_chan_swap;
  logic rx_idle_flag, mf_state_lo, mf_state_hi;

  assign ssm = line_q[LC_SSM_BIT];
  assign clrmm = line_q[LC_CLRMM_BIT];
  assign b_chan_swap = line_q[LC_SWAP_BIT];
  assign rx_idle_flag = (idle_cnt_q == IDLE_RUN);
  assign mf_state_lo = mf_valid_q & mf_st_q[0];
  assign mf_state_hi = mf_valid_q & mf_st_q[1];

  always_comb begin
    rx_status_cnt = rxq_eof_i ? rxq_eof_count_i : rxq_count_i;
    if (ssm) begin
      s_chan_bits = {1'b0, s_vote_q};
    end else begin
      s_chan_bits = s_raw_q;
    end
  end

  always_comb begin
    trig_d = trig_q;
    line_d = line_q;
    rdata_d = {DATA_W{1'b0}};
    if (wr_i) begin
      case (addr_i)
        ADDR_TRIG: trig_d = wdata_i;
        ADDR_LINE_CTRL: line_d = wdata_i & LINE_MASK;
        default: ;
      endcase
    end
    if (rd_i) begin
      case (addr_i)
        ADDR_RX_STATUS: rdata_d = {rxq_eof_i, rx_idle_flag, 1'b0, rx_status_cnt};
        ADDR_TRIG: rdata_d = trig_q;
        ADDR_MF_STATUS: rdata_d = {mfl.mse, mf_state_hi, mf_state_lo, s_chan_bits};
        ADDR_LINE_CTRL: rdata_d = line_q;
        ADDR_ECHO_STATUS: rdata_d = {7'h00, mismatch_q};
        default: rdata_d = {DATA_W{1'b0}};
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      trig_q <= TRIG_RST;
      line_q <= LINE_RST;
      rdata_q <= {DATA_W{1'b0}};
    end else begin
      trig_q <= trig_d;
      line_q <= line_d;
      rdata_q <= rdata_d;
    end
  end

  assign rdata_o = rdata_q;

  // D-channel receive idle and queue interrupts

  logic [3:0] idle_cnt_d;
  logic tx_irq_q, tx_irq_d, rx_irq_q, rx_irq_d;

  always_comb begin
    idle_cnt_d = idle_cnt_q;
    if (d_rx_bit_stb_i) begin
      if (!d_rx_bit_i) begin
        idle_cnt_d = 4'h0;
      end else if (idle_cnt_q != IDLE_RUN) begin
        idle_cnt_d = idle_cnt_q + 4'h1;
      end
    end
    tx_irq_d = thr_reached(txq_empty_i, trig_q[3:0]);
    rx_irq_d = thr_reached(rxq_count_i, trig_q[7:4]);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      idle_cnt_q <= 4'h0;
      tx_irq_q <= 1'b0;
      rx_irq_q <= 1'b0;
    end else begin
      idle_cnt_q <= idle_cnt_d;
      tx_irq_q <= tx_irq_d;
      rx_irq_q <= rx_irq_d;
    end
  end

  assign tx_empty_irq_o = tx_irq_q;
  assign rx_fill_irq_o = rx_irq_q;

  // S channel and multiframe state
  // The vote runs one cycle after the frame strobe so that the tracker's
  // frame number and the raw shift register both describe that frame.

  logic [4:0] s_raw_d;
  logic [3:0] s_vote_d;
  logic [1:0] mf_st_d;
  logic mf_valid_d, s_stb_q, qbm_q, qbm_rise;
  logic [2:0] slot, qs;

  always_comb begin
    s_raw_d = s_raw_q;
    s_vote_d = s_vote_q;
    mf_st_d = mf_st_q;
    mf_valid_d = mf_valid_q;
    slot = vote_slot(mfl.frame_no);
    qs = q_state(mfl.frame_no);
    qbm_rise = qbm_i & ~qbm_q;
    if (frame_stb_i) begin
      s_raw_d = {s_bit_i, s_raw_q[4:1]};
    end
    if (s_stb_q && slot[2]) begin
      s_vote_d[slot[1:0]] = majority5(s_raw_q);
    end
    if (!mfl.mse) begin
      mf_valid_d = 1'b0;
    end else if (qbm_rise && qs[2] && (mf_valid_q || mfl.frame_no == QF_D)) begin
      mf_st_d = qs[1:0];
      mf_valid_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_raw_q <= 5'h00;
      s_vote_q <= 4'h0;
      mf_st_q <= 2'h0;
      mf_valid_q <= 1'b0;
      s_stb_q <= 1'b0;
      qbm_q <= 1'b0;
    end else begin
      s_raw_q <= s_raw_d;
      s_vote_q <= s_vote_d;
      mf_st_q <= mf_st_d;
      mf_valid_q <= mf_valid_d;
      s_stb_q <= frame_stb_i;
      qbm_q <= qbm_i;
    end
  end

  // Echo mismatch; a new mismatch beats a clearing read in the same cycle

  logic mismatch_d, off_q, off_d;

  always_comb begin
    mismatch_d = mismatch_q;
    off_d = clrmm;
    if (clrmm) begin
      mismatch_d = 1'b0;
    end else if (echo_mismatch_i) begin
      mismatch_d = 1'b1;
    end else if (rd_i && addr_i == ADDR_ECHO_STATUS) begin
      mismatch_d = 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mismatch_q <= 1'b0;
      off_q <= 1'b0;
    end else begin
      mismatch_q <= mismatch_d;
      off_q <= off_d;
    end
  end

  assign d_tx_force_ones_o = mismatch_q;
  assign d_contention_off_o = off_q;

  // B-channel exchange

  logic [7:0] te_b1_q, te_b1_d, te_b2_q, te_b2_d;
  logic [7:0] nt_b1_q, nt_b1_d, nt_b2_q, nt_b2_d;

  always_comb begin
    te_b1_d = te_b1_q;
    te_b2_d = te_b2_q;
    nt_b1_d = nt_b1_q;
    nt_b2_d = nt_b2_q;
    if (b_byte_stb_i) begin
      if (b_chan_swap) begin
        te_b1_d = nt_rx_b2_i;
        te_b2_d = nt_rx_b1_i;
        nt_b1_d = tx_second_bchan_in_i;
        nt_b2_d = tx_first_bchan_in_i;
      end else begin
        te_b1_d = nt_rx_b1_i;
        te_b2_d = nt_rx_b2_i;
        nt_b1_d = tx_first_bchan_in_i;
        nt_b2_d = tx_second_bchan_in_i;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      te_b1_q <= 8'h00;
      te_b2_q <= 8'h00;
      nt_b1_q <= 8'h00;
      nt_b2_q <= 8'h00;
    end else begin
      te_b1_q <= te_b1_d;
      te_b2_q <= te_b2_d;
      nt_b1_q <= nt_b1_d;
      nt_b2_q <= nt_b2_d;
    end
  end

  assign rx_serial_out_b1_o = te_b1_q;
  assign rx_serial_out_b2_o = te_b2_q;
  assign nt_tx_b1_o = nt_b1_q;
  assign nt_tx_b2_o = nt_b2_q;

  a_idle_after_run: assert property (@(posedge clk_i) disable iff (rst_i)
    d_rx_bit_stb_i && d_rx_bit_i && idle_cnt_q == 4'hE |=> rx_idle_flag)
    else $error("idle not set after fifteen ones");
  a_eof_count_read: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_i && addr_i == ADDR_RX_STATUS && rxq_eof_i
    |=> rdata_o[7] && rdata_o[4:0] == $past(rxq_eof_count_i))
    else $error("status count ignores end of frame");
  a_tx_empty_full: assert property (@(posedge clk_i) disable iff (rst_i)
    trig_q[3:0] == 4'h0 && txq_empty_i < QUEUE_FULL |=> !tx_empty_irq_o)
    else $error("transmit empty fired below full emptiness");
  a_rx_fill_level: assert property (@(posedge clk_i) disable iff (rst_i)
    trig_q[7:4] != 4'h0 && rxq_count_i >= {1'b0, trig_q[7:4]} |=> rx_fill_irq_o)
    else $error("receive fill missed its level");
  a_voted_top_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_i && addr_i == ADDR_MF_STATUS && ssm |=> !rdata_o[4])
    else $error("voted S word has bit four set");
  a_state_only_qbm: assert property (@(posedge clk_i) disable iff (rst_i)
    !qbm_rise |=> $stable(mf_st_q)) else $error("state moved without marker");
  a_mismatch_sets: assert property (@(posedge clk_i) disable iff (rst_i)
    echo_mismatch_i && !clrmm |=> d_tx_force_ones_o [*1] ##0 mismatch_q)
    else $error("mismatch did not force ones");
  a_swap_b_chan: assert property (@(posedge clk_i) disable iff (rst_i)
    b_byte_stb_i && b_chan_swap |=> rx_serial_out_b1_o == $past(nt_rx_b2_i)
    && nt_tx_b2_o == $past(tx_first_bchan_in_i)) else $error("B channels not exchanged");
endmodule

/* verif/nt_frame_model.sv */
`timescale 1ns/1ns
// Far-end frame source: one frame every eight clocks, M bit in frame 1 when enabled
module nt_frame_model (
  input wire logic clk_i,
  input wire logic run_i,
  input wire logic m_on_i,
  input wire logic [19:0] s_pat_i,
  output logic frame_stb_o,
  output logic m_bit_o,
  output logic s_bit_o,
  output logic qbm_o
);
  logic [2:0] ph_q;
  logic [4:0] idx_q;
  logic m_now;
  logic s_now;
  always_ff @(posedge clk_i) begin
    ph_q <= run_i ? ph_q + 3'h1 : 3'h0;
    if (!run_i) begin
      idx_q <= 5'h01;
    end else if (frame_stb_o) begin
      idx_q <= (idx_q == 5'h14) ? 5'h01 : idx_q + 5'h01;
    end
  end
  assign frame_stb_o = run_i && (ph_q == 3'h7);
  assign m_now = m_on_i && (idx_q == 5'h01);
  assign s_now = s_pat_i[idx_q - 5'h01];
  // Outside the strobe the lines carry junk, so nothing may rely on a held value
  assign m_bit_o = frame_stb_o ? m_now : ~m_now;
  assign s_bit_o = frame_stb_o ? s_now : ~s_now;
  // Marker rises just after frames 1, 6, 11 and 16
  assign qbm_o = run_i && (ph_q == 3'h1 || ph_q == 3'h2) && (idx_q == 5'h02 ||
                 idx_q == 5'h07 || idx_q == 5'h0C || idx_q == 5'h11);
endmodule

/* verif/test_isdn_st_status_control_regs.sv */
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module test_isdn_st_status_control_regs;
  import st_regs_pkg::*;
  localparam logic [19:0] SP = {5'b01001, 5'b11111, 5'b00100, 5'b10110};
  localparam logic [31:0] TRV = {8'h54, 8'h54, 8'h00, 8'h00};
  localparam logic [19:0] TEV = {5'h03, 5'h04, 5'h0F, 5'h10};
  localparam logic [19:0] RCV = {5'h05, 5'h04, 5'h10, 5'h0F};
  localparam logic [7:0] EXV = {2'b01, 2'b10, 2'b01, 2'b10};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [ADDR_W-1:0] addr_i = 4'h0;
  logic [DATA_W-1:0] wdata_i = 8'h00, rdata_o, rd_v;
  logic wr_i = 0, rd_i = 0, d_bit = 0, d_stb = 0, eof = 0, fsync = 0, echo = 0, bstb = 0;
  logic [CNT_W-1:0] rxc = 5'h00, rxe = 5'h00, txe = 5'h00;
  logic tx_irq, rx_irq, force1, cont_off, fstb, mbit, sbit, qbm, run = 0, m_on = 0;
  logic [7:0] nb1 = 8'h11, nb2 = 8'h22, tb1 = 8'h33, tb2 = 8'h44, rb1, rb2, ob1, ob2;
  int num_errors = 0, n_tests = 0, cyc = 0;

  isdn_st_status_control_regs DUT (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .d_rx_bit_i(d_bit),
    .d_rx_bit_stb_i(d_stb), .rxq_count_i(rxc), .rxq_eof_count_i(rxe), .rxq_eof_i(eof),
    .txq_empty_i(txe), .tx_empty_irq_o(tx_irq), .rx_fill_irq_o(rx_irq), .frame_stb_i(fstb),
    .frame_sync_i(fsync), .m_bit_i(mbit), .s_bit_i(sbit), .qbm_i(qbm),
    .echo_mismatch_i(echo), .d_tx_force_ones_o(force1), .d_contention_off_o(cont_off),
    .b_byte_stb_i(bstb), .nt_rx_b1_i(nb1), .nt_rx_b2_i(nb2), .tx_first_bchan_in_i(tb1),
    .tx_second_bchan_in_i(tb2), .rx_serial_out_b1_o(rb1), .rx_serial_out_b2_o(rb2),
    .nt_tx_b1_o(ob1), .nt_tx_b2_o(ob2));
  nt_frame_model nt (.clk_i(clk_i), .run_i(run), .m_on_i(m_on), .s_pat_i(SP),
    .frame_stb_o(fstb), .m_bit_o(mbit), .s_bit_o(sbit), .qbm_o(qbm));

  initial begin
    forever #10 clk_i = ~clk_i;
  end

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // A hang is cut short long after the thousand or so cycles the tests need
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      report_and_stop();
    end
  end

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  // Data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rchk(input string nm, input logic [3:0] a, input logic [7:0] e,
                      input logic [7:0] m);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    rd_v = rdata_o & m;
    `CHK(nm, e, rd_v)
  endtask

  task automatic settle();
    repeat (2) @(posedge clk_i);
    #1;
  endtask

  task automatic dbits(input int n, input logic b);
    repeat (n) begin
      @(posedge clk_i);
      d_bit <= b;
      d_stb <= 1'b1;
      @(posedge clk_i);
      d_stb <= 1'b0;
    end
  endtask

  task automatic frames(input int n);
    repeat (n) begin
      @(posedge clk_i);
      while (!fstb) @(posedge clk_i);
    end
  endtask

  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rchk("trig reset", ADDR_TRIG, TRIG_RST, 8'hFF);
    rchk("line reset", ADDR_LINE_CTRL, LINE_RST, 8'hFF);
    rchk("unmapped", 4'hF, 8'h00, 8'hFF);
    reg_wr(ADDR_LINE_CTRL, 8'hFF);
    rchk("line mask", ADDR_LINE_CTRL, LINE_MASK, 8'hFF);
    reg_wr(ADDR_LINE_CTRL, 8'h00);
    $display("test registers done");

    for (int i = 0; i < 4; i++) begin
      reg_wr(ADDR_TRIG, TRV[i*8 +: 8]);
      @(posedge clk_i);
      txe <= TEV[i*5 +: 5];
      rxc <= RCV[i*5 +: 5];
      settle();
      `CHK("tx empty irq", EXV[i*2+1], tx_irq)
      `CHK("rx fill irq", EXV[i*2], rx_irq)
    end
    $display("test triggers done");

    @(posedge clk_i);
    rxc <= 5'h09;
    rxe <= 5'h03;
    dbits(14, 1'b1);
    rchk("idle 14", ADDR_RX_STATUS, 8'h09, 8'hFF);
    dbits(1, 1'b1);
    rchk("idle 15", ADDR_RX_STATUS, 8'h49, 8'hFF);
    eof <= 1'b1;
    rchk("eof count", ADDR_RX_STATUS, 8'hC3, 8'hFF);
    dbits(1, 1'b0);
    rchk("idle broken", ADDR_RX_STATUS, 8'h83, 8'hFF);
    $display("test rx status done");

    @(posedge clk_i);
    echo <= 1'b1;
    @(posedge clk_i);
    echo <= 1'b0;
    settle();
    `CHK("force ones", 1'b1, force1)
    rchk("mismatch set", ADDR_ECHO_STATUS, 8'h01, 8'h01);
    rchk("mismatch cleared", ADDR_ECHO_STATUS, 8'h00, 8'h01);
    `CHK("force released", 1'b0, force1)
    reg_wr(ADDR_LINE_CTRL, 8'h01);
    settle();
    `CHK("contention off", 1'b1, cont_off)
    @(posedge clk_i);
    echo <= 1'b1;
    @(posedge clk_i);
    echo <= 1'b0;
    rchk("mismatch held", ADDR_ECHO_STATUS, 8'h00, 8'h01);
    reg_wr(ADDR_LINE_CTRL, 8'h00);
    $display("test echo done");

    for (int s = 0; s < 2; s++) begin
      reg_wr(ADDR_LINE_CTRL, s[0] ? 8'h02 : 8'h00);
      @(posedge clk_i);
      bstb <= 1'b1;
      @(posedge clk_i);
      bstb <= 1'b0;
      settle();
      `CHK("to te b1", s[0] ? nb2 : nb1, rb1)
      `CHK("to te b2", s[0] ? nb1 : nb2, rb2)
      `CHK("to nt b1", s[0] ? tb2 : tb1, ob1)
      `CHK("to nt b2", s[0] ? tb1 : tb2, ob2)
    end
    reg_wr(ADDR_LINE_CTRL, 8'h00);
    $display("test swap done");

    @(posedge clk_i);
    fsync <= 1'b1;
    m_on <= 1'b1;
    run <= 1'b1;
    frames(20);
    rchk("raw s bits", ADDR_MF_STATUS, {3'b000, SP[19:15]}, 8'hFF);
    frames(7);
    rchk("no sync yet", ADDR_MF_STATUS, 8'h00, 8'h80);
    frames(1);
    rchk("sync frame 28", ADDR_MF_STATUS, {3'b100, SP[7:3]}, 8'hFF);
    reg_wr(ADDR_LINE_CTRL, 8'h20);
    frames(12);
    rchk("voted", ADDR_MF_STATUS, 8'h85, 8'hFF);
    frames(1);
    repeat (4) @(posedge clk_i);
    rchk("state one", ADDR_MF_STATUS, 8'hA5, 8'hFF);
    // M withheld from frame 61 on: sync must hold through frame 67 and drop at 68
    m_on <= 1'b0;
    frames(26);
    rchk("state two", ADDR_MF_STATUS, 8'hC5, 8'hFF);
    frames(1);
    rchk("missing m drop", ADDR_MF_STATUS, 8'h05, 8'hFF);
    // M back at frames 81 and 101: sync again at frame 108
    m_on <= 1'b1;
    frames(40);
    rchk("resync", ADDR_MF_STATUS, 8'h85, 8'hFF);
    fsync <= 1'b0;
    rchk("sync lost", ADDR_MF_STATUS, 8'h00, 8'h80);
    run <= 1'b0;
    $display("test multiframe done");
    report_and_stop();
  end
endmodule
